// ==== common/pbsc_pkg.sv ====
// Package with constants and types of the PHY basic control and strap block
// Overview of operation
// - Multi-function light drives either light zero or clash pin, per multi-function light register bits 1:0.
// - Light pin strapped low at reset becomes an active-high driver.
// - Light pin strapped high at reset becomes an active-low driver.
// - Five-bit PHY address captured from straps at reset; only it is answered.
// - Without address strap resistors the PHY address is one.
// - Clear-on-read fields are read-only and clear when the host reads them.
// - Latched-high fields set on their condition and hold until read.
// - Latched-low fields clear on their condition and hold until read.
// - Strap-type fields take their reset default from captured strap levels.
// - Self-clearing bits accept a one, start an action, clear when done.
// - Event fields follow the event live, without host action.
// - Control bit 15 starts a soft reset, reads one until done.
// - Soft reset keeps vendor registers and does not re-capture straps.
// - With negotiation off, bit 13 selects 100 or 10 Mbps; strap default.
// - Bit 12 enables negotiation; when off bits 8 and 13 fix mode.
// - Power down is bit 11 ORed with the low pin; pin sets the bit.
// - Power down keeps programmed registers, holds state machines in reset.
// - With negotiation off, bit 8 selects full or half duplex.
// - Control bit 10 isolates the MAC data interface, management stays active.
package pbsc_pkg;
  localparam logic [4:0] REG_BASIC = 5'h00;
  localparam logic [4:0] REG_CTL = 5'h0D;
  localparam logic [4:0] REG_ADAT = 5'h0E;
  localparam logic [4:0] REG_EVT = 5'h11;
  localparam logic [15:0] EXT_MULTI_FUNCTION_LIGHT = 16'h0025;
  localparam logic [15:0] EXT_LCFG = 16'h0460;
  localparam int BC_RST = 15;
  localparam int BC_LOOP = 14;
  localparam int BC_SPD = 13;
  localparam int BC_AN = 12;
  localparam int BC_PD = 11;
  localparam int BC_ISO = 10;
  localparam int BC_DUP = 8;
  localparam logic [15:0] BC_RW_MASK = 16'h7D80;
  localparam int STR_LZ = 5;
  localparam int STR_LO = 6;
  localparam int STR_CL = 7;
  localparam int STR_SPD = 8;
  localparam int STR_AN = 9;
  localparam int STR_DUP = 10;
  localparam logic [1:0] MULTI_FUNCTION_LIGHT_TO_CLASH = 2'h1;
  localparam logic [4:0] PHY_ADDR_DFLT = 5'h01;
  localparam logic [15:0] MULTI_FUNCTION_LIGHT_RST = 16'h0000;
  localparam logic [15:0] LCFG_RST = 16'h0000;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam logic LL_RST = 1'b1;
  localparam logic PD_PIN_IDLE = 1'b1;
  localparam logic [5:0] PRE_ONES = 6'h20;
  localparam logic [5:0] HDR_LAST = 6'h0C;
  localparam logic [5:0] DAT_LAST = 6'h0F;
  localparam logic [1:0] OP_RD = 2'h2;
  localparam logic [1:0] OP_WR = 2'h1;
  localparam int CLK_MHZ = 100;
  localparam int SW_RST_NS = 1000;
  localparam logic [7:0] SW_RST_CYC = 8'((SW_RST_NS * CLK_MHZ + 999) / 1000);
  typedef enum logic [1:0] {ST_PRE = 2'h0, ST_HDR = 2'h1, ST_TA = 2'h3, ST_DAT = 2'h2} pbsc_mdio_e;
  typedef enum logic [2:0] {SEL_NONE, SEL_BASIC, SEL_CTL, SEL_ADDR, SEL_EVT, SEL_MULTI_FUNCTION_LIGHT, SEL_LCFG} pbsc_sel_e;
  typedef struct packed {
    logic mdcS1, mdcS2, mdcP, mdioS1, mdioS2, pdS1, pdS2;
    logic [10:0] strS1, strS2;
    logic [1:0] strapCnt;
    logic ready;
    logic [4:0] phyAddr;
    logic polZ, polO, polC;
    logic [2:0] strapMode;
    logic [15:0] bc, multi_function_light, lcfg, ctl, ea;
    logic [7:0] rstCnt;
    logic evFault, evLink;
    logic [7:0] evCnt;
    pbsc_mdio_e st;
    logic [5:0] cnt;
    logic [15:0] sh;
    logic isRd;
    logic [4:0] ra;
    logic mdoOut, mdoOe, lzOut, loOut, clOut, ledOe;
    logic [3:0] rxd;
    logic rxdOe, spd100, fullDup, anEn, sleep, smRst;
  } pbsc_state_s;
endpackage

// ==== core/pbsc_core.sv ====
// PHY basic control, strap capture, light routing and management slave
`timescale 1ns/1ps
module pbsc_core
  import pbsc_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Management bus
  input wire logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  // Straps and power-down pin
  input wire logic [4:0] phyAddrStrap,
  input wire logic speedStrap,
  input wire logic anegStrap,
  input wire logic duplexStrap,
  input wire logic irqOrSleepN,
  // Light pins
  input wire logic statusLightZeroIn,
  output logic statusLightZeroOut,
  output logic statusLightZeroOe,
  input wire logic statusLightOneIn,
  output logic statusLightOneOut,
  output logic statusLightOneOe,
  input wire logic clashLightIn,
  output logic clashLightOut,
  output logic clashLightOe,
  // PHY core status
  input wire logic linkUpIn,
  input wire logic activityIn,
  input wire logic remoteFaultIn,
  input wire logic errPulseIn,
  input wire logic collisionIn,
  input wire logic anSpeed100In,
  input wire logic anFullDupIn,
  // MII data
  input wire logic [3:0] txd,
  input wire logic [3:0] lineRxd,
  output logic [3:0] macRxd,
  output logic macRxdOe,
  // Mode outputs
  output logic speed100,
  output logic fullDuplex,
  output logic anEnable,
  output logic sleep,
  output logic pcsReset
);

  function automatic pbsc_sel_e regSel(input logic [4:0] ra, input logic [15:0] ctl, input logic [15:0] ea);
    pbsc_sel_e s;
    s = SEL_NONE;
    case (ra)
      REG_BASIC: s = SEL_BASIC;
      REG_CTL: s = SEL_CTL;
      REG_EVT: s = SEL_EVT;
      REG_ADAT: begin
        if (ctl[15:14] == 2'h0) begin
          s = SEL_ADDR;
        end else if (ea == EXT_MULTI_FUNCTION_LIGHT) begin
          s = SEL_MULTI_FUNCTION_LIGHT;
        end else if (ea == EXT_LCFG) begin
          s = SEL_LCFG;
        end
      end
      default: s = SEL_NONE;
    endcase
    return s;
  endfunction

  function automatic logic [15:0] bcDefault(input logic [2:0] mode);
    logic [15:0] v;
    v = 16'h0000;
    v[BC_SPD] = mode[0];
    v[BC_AN] = mode[1];
    v[BC_DUP] = mode[2];
    return v;
  endfunction

  pbsc_state_s s_q;
  pbsc_state_s s_d;
  logic rise;
  logic bitIn;
  logic [12:0] hdr;
  logic [15:0] wd;
  logic [15:0] rdVal;
  pbsc_sel_e rSel;
  pbsc_sel_e wSel;
  logic mledFn;
  logic routed;

  always_comb begin
    s_d = s_q;
    rise = s_q.mdcS2 & ~s_q.mdcP;
    bitIn = s_q.mdioS2;
    hdr = {s_q.sh[11:0], bitIn};
    wd = {s_q.sh[14:0], bitIn};
    rSel = regSel(hdr[4:0], s_q.ctl, s_q.ea);
    wSel = regSel(s_q.ra, s_q.ctl, s_q.ea);
    routed = (s_q.multi_function_light[1:0] == MULTI_FUNCTION_LIGHT_TO_CLASH);
    case (s_q.lcfg[1:0])
      2'h0: mledFn = linkUpIn;
      2'h1: mledFn = activityIn;
      2'h2: mledFn = s_q.spd100;
      default: mledFn = s_q.fullDup;
    endcase
    case (rSel)
      SEL_BASIC: rdVal = s_q.bc | {(s_q.rstCnt != 8'h00), 15'h0000};
      SEL_CTL: rdVal = s_q.ctl;
      SEL_ADDR: rdVal = s_q.ea;
      SEL_EVT: rdVal = {s_q.evCnt, 5'h00, activityIn, s_q.evLink, s_q.evFault};
      SEL_MULTI_FUNCTION_LIGHT: rdVal = s_q.multi_function_light;
      SEL_LCFG: rdVal = s_q.lcfg;
      default: rdVal = 16'h0000;
    endcase
    // Synchronisers for pins and the management clock
    s_d.mdcS1 = mdc;
    s_d.mdcS2 = s_q.mdcS1;
    s_d.mdcP = s_q.mdcS2;
    s_d.mdioS1 = mdioIn;
    s_d.mdioS2 = s_q.mdioS1;
    s_d.pdS1 = irqOrSleepN;
    s_d.pdS2 = s_q.pdS1;
    s_d.strS1 = {duplexStrap, anegStrap, speedStrap, clashLightIn,
                 statusLightOneIn, statusLightZeroIn, phyAddrStrap};
    s_d.strS2 = s_q.strS1;
    // Strap capture once after reset release
    if (s_q.strapCnt != 2'h0) begin
      s_d.strapCnt = s_q.strapCnt - 2'h1;
    end
    if (s_q.strapCnt == 2'h1) begin
      s_d.phyAddr = s_q.strS2[4:0];
      s_d.polZ = s_q.strS2[STR_LZ];
      s_d.polO = s_q.strS2[STR_LO];
      s_d.polC = s_q.strS2[STR_CL];
      s_d.strapMode = {s_q.strS2[STR_DUP], s_q.strS2[STR_AN], s_q.strS2[STR_SPD]};
      s_d.bc = bcDefault({s_q.strS2[STR_DUP], s_q.strS2[STR_AN], s_q.strS2[STR_SPD]});
      s_d.bc[BC_PD] = ~s_q.pdS2;
      s_d.ready = 1'b1;
    end
    // Latched and counted status
    s_d.evFault = s_q.evFault | remoteFaultIn;
    s_d.evLink = s_q.evLink & linkUpIn;
    if (errPulseIn && s_q.evCnt != 8'hFF) begin
      s_d.evCnt = s_q.evCnt + 8'h01;
    end
    if (!s_q.pdS2) begin
      s_d.bc[BC_PD] = 1'b1;
    end
    if (s_q.rstCnt != 8'h00) begin
      s_d.rstCnt = s_q.rstCnt - 8'h01;
    end
    // Management frame engine
    if (rise) begin
      case (s_q.st)
        ST_PRE: begin
          if (bitIn) begin
            if (s_q.cnt != PRE_ONES) begin
              s_d.cnt = s_q.cnt + 6'h01;
            end
          end else begin
            if (s_q.cnt == PRE_ONES) begin
              s_d.st = ST_HDR;
            end
            s_d.cnt = 6'h00;
          end
        end
        ST_HDR: begin
          s_d.sh = {s_q.sh[14:0], bitIn};
          s_d.cnt = s_q.cnt + 6'h01;
          if (s_q.cnt == HDR_LAST) begin
            s_d.cnt = 6'h00;
            if (hdr[12] && hdr[9:5] == s_q.phyAddr && (hdr[11:10] == OP_RD || hdr[11:10] == OP_WR)) begin
              s_d.st = ST_TA;
              s_d.isRd = (hdr[11:10] == OP_RD);
              s_d.ra = hdr[4:0];
              if (hdr[11:10] == OP_RD) begin
                s_d.sh = rdVal;
                if (rSel == SEL_EVT) begin
                  s_d.evFault = remoteFaultIn;
                  s_d.evLink = linkUpIn;
                  s_d.evCnt = {7'h00, errPulseIn};
                end
              end
            end else begin
              s_d.st = ST_PRE;
            end
          end
        end
        ST_TA: begin
          s_d.cnt = s_q.cnt + 6'h01;
          if (s_q.cnt == 6'h00) begin
            s_d.mdoOe = s_q.isRd;
            s_d.mdoOut = 1'b0;
          end else begin
            s_d.st = ST_DAT;
            s_d.cnt = 6'h00;
            if (s_q.isRd) begin
              s_d.mdoOut = s_q.sh[15];
              s_d.sh = {s_q.sh[14:0], 1'b0};
            end
          end
        end
        ST_DAT: begin
          s_d.cnt = s_q.cnt + 6'h01;
          if (s_q.isRd) begin
            s_d.mdoOut = s_q.sh[15];
            s_d.sh = {s_q.sh[14:0], 1'b0};
          end else begin
            s_d.sh = wd;
          end
          if (s_q.cnt == DAT_LAST) begin
            s_d.st = ST_PRE;
            s_d.cnt = 6'h00;
            s_d.mdoOe = 1'b0;
            s_d.mdoOut = 1'b0;
            if (!s_q.isRd) begin
              case (wSel)
                SEL_BASIC: begin
                  if (wd[BC_RST]) begin
                    s_d.bc = bcDefault(s_q.strapMode);
                    s_d.bc[BC_PD] = ~s_q.pdS2;
                    s_d.rstCnt = SW_RST_CYC;
                    s_d.ctl = 16'h0000;
                    s_d.ea = 16'h0000;
                    s_d.evFault = remoteFaultIn;
                    s_d.evLink = linkUpIn;
                    s_d.evCnt = 8'h00;
                  end else begin
                    s_d.bc = wd & BC_RW_MASK;
                    s_d.bc[BC_PD] = wd[BC_PD] | ~s_q.pdS2;
                  end
                end
                SEL_CTL: s_d.ctl = wd;
                SEL_ADDR: s_d.ea = wd;
                SEL_MULTI_FUNCTION_LIGHT: s_d.multi_function_light = wd;
                SEL_LCFG: s_d.lcfg = wd;
                default: s_d.ctl = s_q.ctl;
              endcase
            end
          end
        end
        default: s_d.st = ST_PRE;
      endcase
    end
    // Registered pin and mode outputs
    s_d.ledOe = s_q.ready;
    s_d.lzOut = (routed ? 1'b0 : mledFn) ^ s_q.polZ;
    s_d.clOut = (routed ? mledFn : collisionIn) ^ s_q.polC;
    s_d.loOut = s_q.spd100 ^ s_q.polO;
    s_d.rxd = s_q.bc[BC_LOOP] ? txd : lineRxd;
    s_d.rxdOe = ~s_q.bc[BC_ISO];
    s_d.anEn = s_q.bc[BC_AN];
    s_d.spd100 = s_q.bc[BC_AN] ? anSpeed100In : s_q.bc[BC_SPD];
    s_d.fullDup = s_q.bc[BC_AN] ? anFullDupIn : s_q.bc[BC_DUP];
    s_d.sleep = s_q.bc[BC_PD] | ~s_q.pdS2;
    s_d.smRst = s_q.bc[BC_PD] | ~s_q.pdS2 | (s_q.rstCnt != 8'h00);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.strapCnt <= STRAP_WAIT;
      s_q.phyAddr <= PHY_ADDR_DFLT;
      s_q.multi_function_light <= MULTI_FUNCTION_LIGHT_RST;
      s_q.lcfg <= LCFG_RST;
      s_q.evLink <= LL_RST;
      s_q.pdS1 <= PD_PIN_IDLE;
      s_q.pdS2 <= PD_PIN_IDLE;
      s_q.st <= ST_PRE;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign mdioOut = s_q.mdoOut;
  assign mdioOe = s_q.mdoOe;
  assign statusLightZeroOut = s_q.lzOut;
  assign statusLightZeroOe = s_q.ledOe;
  assign statusLightOneOut = s_q.loOut;
  assign statusLightOneOe = s_q.ledOe;
  assign clashLightOut = s_q.clOut;
  assign clashLightOe = s_q.ledOe;
  assign macRxd = s_q.rxd;
  assign macRxdOe = s_q.rxdOe;
  assign speed100 = s_q.spd100;
  assign fullDuplex = s_q.fullDup;
  assign anEnable = s_q.anEn;
  assign sleep = s_q.sleep;
  assign pcsReset = s_q.smRst;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_capt;
    s_q.strapCnt == 2'h1 && ce;
  endsequence

  property p_route;
    s_q.ready && ce && routed |=> statusLightZeroOut == s_q.polZ;
  endproperty
  a_route: assert property (p_route) else $error("light zero lit while routed away");

  property p_pol;
    s_capt |=> s_q.polZ == $past(s_q.strS2[STR_LZ]) && s_q.polO == $past(s_q.strS2[STR_LO]);
  endproperty
  a_pol: assert property (p_pol) else $error("light polarity not taken from strap");

  property p_oe;
    s_capt ##1 ce |=> statusLightZeroOe && clashLightOe;
  endproperty
  a_oe: assert property (p_oe) else $error("light pins not driven after strap capture");

  property p_addr;
    s_capt |=> s_q.phyAddr == $past(s_q.strS2[4:0]);
  endproperty
  a_addr: assert property (p_addr) else $error("address not captured from strap");

  property p_dflt;
    s_q.strapCnt > 2'h1 |-> s_q.phyAddr == PHY_ADDR_DFLT;
  endproperty
  a_dflt: assert property (p_dflt) else $error("address default wrong");

  property p_lh;
    remoteFaultIn && ce |=> s_q.evFault;
  endproperty
  a_lh: assert property (p_lh) else $error("latched-high fault lost");

  property p_ll;
    !linkUpIn && ce |=> !s_q.evLink;
  endproperty
  a_ll: assert property (p_ll) else $error("latched-low link lost");

  property p_busy;
    s_q.rstCnt != 8'h00 && ce |=> pcsReset;
  endproperty
  a_busy: assert property (p_busy) else $error("soft reset not held");

  property p_keep;
    s_q.strapCnt == 2'h0 && s_q.rstCnt != 8'h00 |-> $stable(s_q.phyAddr);
  endproperty
  a_keep: assert property (p_keep) else $error("straps changed by soft reset");

  property p_loop;
    s_q.bc[BC_LOOP] && ce |=> macRxd == $past(txd);
  endproperty
  a_loop: assert property (p_loop) else $error("loopback data wrong");

  property p_pd;
    !s_q.pdS2 && ce |=> s_q.bc[BC_PD] && sleep;
  endproperty
  a_pd: assert property (p_pd) else $error("pin did not set power down");

  property p_iso;
    s_q.bc[BC_ISO] && ce |=> !macRxdOe;
  endproperty
  a_iso: assert property (p_iso) else $error("isolate did not release data");

endmodule

// ==== tb/pbsc_smc_model.sv ====
// Station management controller model for the serial management bus
`timescale 1ns/1ps
module pbsc_smc_model
  import pbsc_pkg::*;
(
  // Management bus
  output logic mdc,
  output logic mdioDrv,
  output logic mdioEn,
  input wire logic mdioLine
);
  logic taSeen;
  initial begin
    mdc = 1'b0;
    mdioDrv = 1'b1;
    mdioEn = 1'b0;
    taSeen = 1'b1;
  end
  // One mdc period; data changes while mdc is low, held over the rising edge
  task automatic bitx(input logic b, input logic en, output logic s);
    mdioEn = en;
    mdioDrv = b;
    #62.5 mdc = 1'b1;
    s = mdioLine;
    #62.5 mdc = 1'b0;
  endtask
  // Whole frame with full preamble; mdc stands low between frames
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic s;
    logic rdOp;
    logic [13:0] hdr;
    hdr = {2'b01, op, phy, ra};
    rdOp = (op == OP_RD);
    for (int i = 0; i < 32; i++) bitx(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bitx(hdr[i], 1'b1, s);
    bitx(1'b1, !rdOp, s);
    bitx(1'b0, !rdOp, taSeen);
    for (int i = 15; i >= 0; i--) begin
      bitx(wd[i], !rdOp, s);
      rd[i] = s;
    end
    mdioEn = 1'b0;
  endtask
endmodule

// ==== tb/tb_top.sv ====
// Self-checking testbench of the PHY basic control and strap block
`timescale 1ns/1ps
module tb_top
  import pbsc_pkg::*;
;
  logic clk, rst_n, mdc, mdioDrv, mdioEn, mdioIn, mdioOut, mdioOe;
  logic [4:0] phyAddrStrap, phyUse;
  logic speedStrap, anegStrap, duplexStrap, irqOrSleepN;
  logic lzIn, lzOut, lzOe, loIn, loOut, loOe, clIn, clOut, clOe;
  logic linkUpIn, activityIn, remoteFaultIn, errPulseIn, collisionIn, anSpeed100In, anFullDupIn;
  logic [3:0] txd, lineRxd, macRxd;
  logic macRxdOe, speed100, fullDuplex, anEnable, sleep, pcsReset;
  logic [15:0] rd;
  int n_errors, compares;
  // Pull-up on the data line; light pins pulled zero low, one and clash high
  assign mdioIn = mdioOe ? mdioOut : (mdioEn ? mdioDrv : 1'b1);
  assign lzIn = lzOe ? lzOut : 1'b0;
  assign loIn = loOe ? loOut : 1'b1;
  assign clIn = clOe ? clOut : 1'b1;
  initial clk = 1'b0;
  always #5 clk = ~clk;
  pbsc_smc_model u_smc (.mdc(mdc), .mdioDrv(mdioDrv), .mdioEn(mdioEn), .mdioLine(mdioIn));
  pbsc_core u_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut),
    .mdioOe(mdioOe), .phyAddrStrap(phyAddrStrap), .speedStrap(speedStrap), .anegStrap(anegStrap),
    .duplexStrap(duplexStrap), .irqOrSleepN(irqOrSleepN), .statusLightZeroIn(lzIn),
    .statusLightZeroOut(lzOut), .statusLightZeroOe(lzOe), .statusLightOneIn(loIn),
    .statusLightOneOut(loOut), .statusLightOneOe(loOe), .clashLightIn(clIn), .clashLightOut(clOut),
    .clashLightOe(clOe), .linkUpIn(linkUpIn), .activityIn(activityIn), .remoteFaultIn(remoteFaultIn),
    .errPulseIn(errPulseIn), .collisionIn(collisionIn), .anSpeed100In(anSpeed100In),
    .anFullDupIn(anFullDupIn), .txd(txd), .lineRxd(lineRxd), .macRxd(macRxd), .macRxdOe(macRxdOe),
    .speed100(speed100), .fullDuplex(fullDuplex), .anEnable(anEnable), .sleep(sleep),
    .pcsReset(pcsReset));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Frames start 1 ns after a falling edge so mdc never meets a clock edge
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    @(negedge clk);
    #1 u_smc.frame(OP_WR, phyUse, ra, d, x);
  endtask
  task automatic rdr(input logic [4:0] phy, input logic [4:0] ra, output logic [15:0] d);
    @(negedge clk);
    #1 u_smc.frame(OP_RD, phy, ra, 16'h0000, d);
  endtask
  task automatic rdChk(input logic [4:0] ra, input logic [15:0] exp);
    rdr(phyUse, ra, rd);
    check(rd, exp);
  endtask
  task automatic extSel(input logic [15:0] ea);
    wr(REG_CTL, 16'h001F);
    wr(REG_ADAT, ea);
    wr(REG_CTL, 16'h401F);
  endtask
  // Lets the mdc synchroniser and output registers catch up
  task automatic settle;
    repeat (10) @(negedge clk);
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    print_verdict();
  end
  initial begin
    rst_n = 1'b0;
    phyAddrStrap = 5'h1F;
    phyUse = 5'h1F;
    {speedStrap, anegStrap, duplexStrap, irqOrSleepN} = 4'b1011;
    {linkUpIn, activityIn, remoteFaultIn, errPulseIn, collisionIn} = 5'b10000;
    {anSpeed100In, anFullDupIn} = 2'b10;
    txd = 4'hA;
    lineRxd = 4'h5;
    n_errors = 0;
    compares = 0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    settle();
    check({lzOe, loOe, clOe}, 16'h0007);
    rdChk(REG_BASIC, 16'h2100);
    check(u_smc.taSeen, 16'h0000);
    check({speed100, fullDuplex, anEnable}, 16'h0006);
    rdr(5'h1E, REG_BASIC, rd);
    check(rd, 16'hFFFF);
    wr(REG_BASIC, 16'h0000);
    settle();
    check({speed100, fullDuplex, anEnable}, 16'h0000);
    wr(REG_BASIC, 16'h1000);
    settle();
    check({speed100, fullDuplex, anEnable}, 16'h0005);
    wr(REG_BASIC, 16'h4000);
    settle();
    check({macRxdOe, macRxd}, 16'h001A);
    wr(REG_BASIC, 16'h0400);
    settle();
    check({macRxdOe, macRxd}, 16'h0005);
    wr(REG_BASIC, 16'h4800);
    settle();
    check({sleep, pcsReset}, 16'h0003);
    rdChk(REG_BASIC, 16'h4800);
    wr(REG_BASIC, 16'h0000);
    irqOrSleepN = 1'b0;
    settle();
    check(sleep, 16'h0001);
    rdChk(REG_BASIC, 16'h0800);
    irqOrSleepN = 1'b1;
    wr(REG_BASIC, 16'h0000);
    settle();
    check(sleep, 16'h0000);
    {remoteFaultIn, linkUpIn, activityIn} = 3'b101;
    repeat (3) begin
      @(negedge clk) errPulseIn = 1'b1;
      @(negedge clk) errPulseIn = 1'b0;
    end
    {remoteFaultIn, linkUpIn} = 2'b01;
    rdChk(REG_EVT, 16'h0305);
    wr(REG_EVT, 16'hFFFF);
    rdChk(REG_EVT, 16'h0006);
    check({lzOut, loOut, clOut}, 16'h0007);
    collisionIn = 1'b1;
    settle();
    check(clOut, 16'h0000);
    collisionIn = 1'b0;
    extSel(EXT_MULTI_FUNCTION_LIGHT);
    wr(REG_ADAT, {14'h0000, MULTI_FUNCTION_LIGHT_TO_CLASH});
    settle();
    check({lzOut, clOut}, 16'h0000);
    linkUpIn = 1'b0;
    settle();
    check({lzOut, clOut}, 16'h0001);
    linkUpIn = 1'b1;
    phyAddrStrap = 5'h02;
    speedStrap = 1'b0;
    wr(REG_BASIC, 16'h8000);
    repeat (2) @(negedge clk);
    check(pcsReset, 16'h0001);
    repeat (150) @(negedge clk);
    check(pcsReset, 16'h0000);
    rdChk(REG_BASIC, 16'h2100);
    extSel(EXT_MULTI_FUNCTION_LIGHT);
    rdChk(REG_ADAT, 16'h0001);
    phyAddrStrap = 5'h01;
    phyUse = 5'h01;
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    settle();
    rdChk(REG_BASIC, 16'h0100);
    print_verdict();
  end
endmodule
